// >>> verilog/pspd_top.sv
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module pspd_top (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_gate_cmd,
  input  wire pspd_pkg::pspd_cmp_s i_cmp,
  input  wire logic [3:0]          i_strength_code,
  input  wire logic                i_fault_strap_pin,
  output logic                     o_fault_strap_pin,
  output logic                     o_fault_strap_pin_oe,
  output logic                     o_gate_on,
  output logic                     o_slow_turnoff,
  output logic [3:0]               o_drive_code,
  output logic                     o_zero_volt_flag,
  output logic                     o_zero_cross_flag,
  input  wire logic [3:0]          i_s_axi_awaddr,
  input  wire logic                i_s_axi_awvalid,
  output logic                     o_s_axi_awready,
  input  wire logic [31:0]         i_s_axi_wdata,
  input  wire logic [3:0]          i_s_axi_wstrb,
  input  wire logic                i_s_axi_wvalid,
  output logic                     o_s_axi_wready,
  output logic [1:0]               o_s_axi_bresp,
  output logic                     o_s_axi_bvalid,
  input  wire logic                i_s_axi_bready,
  input  wire logic [3:0]          i_s_axi_araddr,
  input  wire logic                i_s_axi_arvalid,
  output logic                     o_s_axi_arready,
  output logic [31:0]              o_s_axi_rdata,
  output logic [1:0]               o_s_axi_rresp,
  output logic                     o_s_axi_rvalid,
  input  wire logic                i_s_axi_rready
);
  import pspd_pkg::*;

  pspd_cmp_s   cmp_s1_reg;     // First synchroniser stage, read only by stage two
  pspd_cmp_s   cmp_reg;        // Synchronised comparator flags
  logic        gate_s1_reg;    // First gate synchroniser stage
  logic        gate_reg;       // Synchronised gate command
  logic        gate_d_reg;     // Previous gate sample for edge detect
  logic        strap_s1_reg;   // Strap pin level, stage one
  logic        strap_reg;      // Strap pin level, stage two
  logic        rise;           // Gate command rising edge

  // Two-flop synchronisers on every asynchronous comparator and the gate
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cmp_s1_reg   <= '0;
      cmp_reg      <= '0;
      gate_s1_reg  <= 1'b0;
      gate_reg     <= 1'b0;
      gate_d_reg   <= 1'b0;
      strap_s1_reg <= 1'b0;
      strap_reg    <= 1'b0;
    end else begin
      cmp_s1_reg   <= i_cmp;
      cmp_reg      <= cmp_s1_reg;
      gate_s1_reg  <= i_gate_cmd;
      gate_reg     <= gate_s1_reg;
      gate_d_reg   <= gate_reg;
      strap_s1_reg <= i_fault_strap_pin;
      strap_reg    <= strap_s1_reg;
    end
  end
  assign rise = gate_reg & ~gate_d_reg;

  // Power-up drive-strength sensing
  logic        sensed_reg,  sensed_next;   // Sensing finished
  logic [15:0] sense_reg,   sense_next;    // Sensing window counter
  logic [3:0]  code_reg,    code_next;     // Captured drive-strength code

  // The code is taken once at the end of the window and never again
  always_comb begin
    sensed_next = sensed_reg;
    sense_next  = sense_reg;
    code_next   = code_reg;
    if (!sensed_reg) begin
      if (sense_reg == SENSE_CYC - 16'h1) begin
        sensed_next = 1'b1;
        code_next   = i_strength_code;
      end else begin
        sense_next  = sense_reg + 16'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sensed_reg <= 1'b0;
      sense_reg  <= 16'h0;
      code_reg   <= 4'h0;
    end else begin
      sensed_reg <= sensed_next;
      sense_reg  <= sense_next;
      code_reg   <= code_next;
    end
  end

  // Protection state
  logic        lim_lat_reg, lim_lat_next;  // cycle_current_limit active this cycle
  logic        lim_won_reg, lim_won_next;  // current_overlimit fired first this cycle
  logic [15:0] trip_reg,    trip_next;     // Time above current_limit_level
  logic        ds_lat_reg,  ds_lat_next;   // desaturation_trip latched
  logic [15:0] dsr_reg,     dsr_next;      // Gate-low time toward latch release
  logic        slow_reg,    slow_next;     // Slowed turn-off strength select
  logic        drv_reg,     drv_next;      // Driver enable
  logic        flt_reg,     flt_next;      // Fault pin level, low means fault
  logic        oe_reg,      oe_next;       // Fault pin drive enable
  logic        fault_any;                  // Any fault source active

  assign fault_any = lim_lat_reg | ds_lat_reg | cmp_reg.over_temp | cmp_reg.supply_undervolt_lockout;

  // Overcurrent, desaturation, temperature and supply handling
  always_comb begin
    lim_lat_next = lim_lat_reg;
    lim_won_next = lim_won_reg;
    trip_next    = 16'h0;
    ds_lat_next  = ds_lat_reg;
    dsr_next     = 16'h0;
    slow_next    = slow_reg;
    if (!gate_reg) begin
      // Gate low ends the overcurrent cycle
      lim_lat_next = 1'b0;
      lim_won_next = 1'b0;
      if (ds_lat_reg) begin
        dsr_next = dsr_reg + 16'h1;
        if (dsr_reg == DESAT_RST_CYC - 16'h1) begin
          ds_lat_next = 1'b0;
          slow_next   = 1'b0;
          dsr_next    = 16'h0;
        end
      end
    end else begin
      if (cmp_reg.current_overlimit) begin
        lim_won_next = 1'b1;
        trip_next    = trip_reg + 16'h1;
        if (trip_reg >= TRIP_CYC - 16'h1) begin
          lim_lat_next = 1'b1;
          trip_next    = trip_reg;
        end
      end
      // Desaturation counts only when overcurrent did not come first
      if (cmp_reg.desaturation_trip && !lim_won_reg) begin
        ds_lat_next = 1'b1;
        slow_next   = 1'b1;
      end
    end
    // Driver on only after sensing and with no fault source
    drv_next  = sensed_reg & gate_reg & ~fault_any & ~lim_lat_next & ~ds_lat_next;
    // Pin stays an input until sensing is done, then push-pull for good
    oe_next   = sensed_reg;
    flt_next  = sensed_reg & ~fault_any;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      lim_lat_reg <= 1'b0;
      lim_won_reg <= 1'b0;
      trip_reg    <= 16'h0;
      ds_lat_reg  <= 1'b0;
      dsr_reg     <= 16'h0;
      slow_reg    <= 1'b0;
      drv_reg     <= 1'b0;
      flt_reg     <= 1'b0;
      oe_reg      <= 1'b0;
    end else begin
      lim_lat_reg <= lim_lat_next;
      lim_won_reg <= lim_won_next;
      trip_reg    <= trip_next;
      ds_lat_reg  <= ds_lat_next;
      dsr_reg     <= dsr_next;
      slow_reg    <= slow_next;
      drv_reg     <= drv_next;
      flt_reg     <= flt_next;
      oe_reg      <= oe_next;
    end
  end

  // Control register bits driven by the bus slave
  logic [1:0]  ctrl_reg,    ctrl_next;

  // Zero-voltage detector
  pspd_zv_e    zv_st_reg,   zv_st_next;    // Detector state
  logic [15:0] zv_cnt_reg,  zv_cnt_next;   // Delay and width counter
  logic [15:0] rc_reg,      rc_next;       // Reverse-conduction run length
  logic        zvf_reg,     zvf_next;      // zero_volt_flag

  // A run shorter than reverse_conduct_min, or none at all, never qualifies
  always_comb begin
    zv_st_next  = zv_st_reg;
    zv_cnt_next = zv_cnt_reg;
    zvf_next    = zvf_reg;
    rc_next     = 16'h0;
    if (!gate_reg && cmp_reg.vds_negative) begin
      rc_next = (rc_reg >= RC_MIN_CYC) ? rc_reg : rc_reg + 16'h1;
    end
    case (zv_st_reg)
      ZV_IDLE: begin
        if (rise && ctrl_reg[CTRL_ZV_EN] && rc_reg >= RC_MIN_CYC) begin
          zv_st_next  = ZV_WAIT;
          zv_cnt_next = 16'h0;
        end
      end
      ZV_WAIT: begin
        zv_cnt_next = zv_cnt_reg + 16'h1;
        if (zv_cnt_reg >= ZV_DLY_CYC - 16'h1) begin
          zv_st_next  = ZV_PULSE;
          zv_cnt_next = 16'h0;
          zvf_next    = 1'b1;
        end
      end
      ZV_PULSE: begin
        zv_cnt_next = zv_cnt_reg + 16'h1;
        if (zv_cnt_reg >= ZV_WID_CYC - 16'h1) begin
          zv_st_next = ZV_IDLE;
          zvf_next   = 1'b0;
        end
      end
      default: begin
        zv_st_next = ZV_IDLE;
        zvf_next   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      zv_st_reg  <= ZV_IDLE;
      zv_cnt_reg <= 16'h0;
      rc_reg     <= 16'h0;
      zvf_reg    <= 1'b0;
    end else begin
      zv_st_reg  <= zv_st_next;
      zv_cnt_reg <= zv_cnt_next;
      rc_reg     <= rc_next;
      zvf_reg    <= zvf_next;
    end
  end

  // Zero-current detector
  pspd_zc_e    zc_st_reg,   zc_st_next;    // Detector state
  logic [15:0] zc_cnt_reg,  zc_cnt_next;   // Blank, delay and width counter
  logic        zc_dly_reg,  zc_dly_next;   // Crossing seen, delay running
  logic        zcf_reg,     zcf_next;      // zero_cross_flag

  // Polarity is not looked at during blanking; a turn-off aborts the search
  always_comb begin
    zc_st_next  = zc_st_reg;
    zc_cnt_next = zc_cnt_reg;
    zc_dly_next = zc_dly_reg;
    zcf_next    = zcf_reg;
    case (zc_st_reg)
      ZC_IDLE: begin
        if (rise && ctrl_reg[CTRL_ZC_EN]) begin
          zc_st_next  = ZC_BLANK;
          zc_cnt_next = 16'h0;
        end
      end
      ZC_BLANK: begin
        zc_cnt_next = zc_cnt_reg + 16'h1;
        if (!gate_reg) begin
          zc_st_next = ZC_IDLE;
        end else if (zc_cnt_reg >= ZC_BLANK_CYC - 16'h1) begin
          zc_cnt_next = 16'h0;
          zc_dly_next = 1'b0;
          if (cmp_reg.current_positive) begin
            zc_st_next = ZC_PULSE;
            zcf_next   = 1'b1;
          end else begin
            zc_st_next = ZC_SEEK;
          end
        end
      end
      ZC_SEEK: begin
        if (zc_dly_reg) begin
          zc_cnt_next = zc_cnt_reg + 16'h1;
          if (zc_cnt_reg >= ZC_DLY_CYC - 16'h1) begin
            zc_st_next  = ZC_PULSE;
            zc_cnt_next = 16'h0;
            zcf_next    = 1'b1;
          end
        end else if (!gate_reg) begin
          zc_st_next = ZC_IDLE;
        end else if (cmp_reg.current_positive) begin
          zc_dly_next = 1'b1;
        end
      end
      ZC_PULSE: begin
        zc_cnt_next = zc_cnt_reg + 16'h1;
        if (zc_cnt_reg >= ZC_WID_CYC - 16'h1) begin
          zc_st_next = ZC_IDLE;
          zcf_next   = 1'b0;
        end
      end
      default: begin
        zc_st_next = ZC_IDLE;
        zcf_next   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      zc_st_reg  <= ZC_IDLE;
      zc_cnt_reg <= 16'h0;
      zc_dly_reg <= 1'b0;
      zcf_reg    <= 1'b0;
    end else begin
      zc_st_reg  <= zc_st_next;
      zc_cnt_reg <= zc_cnt_next;
      zc_dly_reg <= zc_dly_next;
      zcf_reg    <= zcf_next;
    end
  end

  // AXI4-Lite slave
  logic        awh_reg, awh_next;          // Write address held
  logic [3:0]  awa_reg, awa_next;          // Held write address
  logic        wh_reg,  wh_next;           // Write data held
  logic [31:0] wd_reg,  wd_next;           // Held write data
  logic [3:0]  ws_reg,  ws_next;           // Held write strobes
  logic        bv_reg,  bv_next;           // Write response valid
  logic [1:0]  br_reg,  br_next;           // Write response code
  logic        awr_reg, awr_next;          // Address ready
  logic        wr_reg,  wr_next;           // Data ready
  logic        rv_reg,  rv_next;           // Read valid
  logic [31:0] rd_reg,  rd_next;           // Read data
  logic [1:0]  rr_reg,  rr_next;           // Read response code
  logic        arr_reg, arr_next;          // Read address ready
  logic [31:0] stat;                       // Live status word

  assign stat = {22'h0, strap_reg, code_reg, sensed_reg, cmp_reg.supply_undervolt_lockout,
                 cmp_reg.over_temp, ds_lat_reg, lim_lat_reg};

  // Address and data may arrive in either order; unmapped addresses get SLVERR
  always_comb begin
    awh_next  = awh_reg;
    awa_next  = awa_reg;
    wh_next   = wh_reg;
    wd_next   = wd_reg;
    ws_next   = ws_reg;
    bv_next   = bv_reg;
    br_next   = br_reg;
    rv_next   = rv_reg;
    rd_next   = rd_reg;
    rr_next   = rr_reg;
    ctrl_next = ctrl_reg;
    if (i_s_axi_awvalid && awr_reg) begin
      awh_next = 1'b1;
      awa_next = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && wr_reg) begin
      wh_next = 1'b1;
      wd_next = i_s_axi_wdata;
      ws_next = i_s_axi_wstrb;
    end
    if (bv_reg && i_s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (awh_reg && wh_reg && !bv_reg) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = RESP_OKAY;
      if (awa_reg == CTRL_OFS) begin
        if (ws_reg[0]) begin
          ctrl_next = wd_reg[1:0];
        end
      end else if (awa_reg != STAT_OFS) begin
        br_next = RESP_SLVERR;
      end
    end
    if (rv_reg && i_s_axi_rready) begin
      rv_next = 1'b0;
    end
    if (i_s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      if (i_s_axi_araddr == CTRL_OFS) begin
        rd_next = {30'h0, ctrl_reg};
      end else if (i_s_axi_araddr == STAT_OFS) begin
        rd_next = stat;
      end else begin
        rd_next = 32'h0;
        rr_next = RESP_SLVERR;
      end
    end
    // Ready is withheld once a channel holds an item, one write at a time
    awr_next = ~awh_next & ~bv_next;
    wr_next  = ~wh_next & ~bv_next;
    arr_next = ~rv_next;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      awh_reg  <= 1'b0;
      awa_reg  <= 4'h0;
      wh_reg   <= 1'b0;
      wd_reg   <= 32'h0;
      ws_reg   <= 4'h0;
      bv_reg   <= 1'b0;
      br_reg   <= 2'h0;
      awr_reg  <= 1'b0;
      wr_reg   <= 1'b0;
      rv_reg   <= 1'b0;
      rd_reg   <= 32'h0;
      rr_reg   <= 2'h0;
      arr_reg  <= 1'b0;
      ctrl_reg <= CTRL_RST;
    end else begin
      awh_reg  <= awh_next;
      awa_reg  <= awa_next;
      wh_reg   <= wh_next;
      wd_reg   <= wd_next;
      ws_reg   <= ws_next;
      bv_reg   <= bv_next;
      br_reg   <= br_next;
      awr_reg  <= awr_next;
      wr_reg   <= wr_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
      rr_reg   <= rr_next;
      arr_reg  <= arr_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign o_fault_strap_pin    = flt_reg;
  assign o_fault_strap_pin_oe = oe_reg;
  assign o_gate_on            = drv_reg;
  assign o_slow_turnoff       = slow_reg;
  assign o_drive_code         = code_reg;
  assign o_zero_volt_flag     = zvf_reg;
  assign o_zero_cross_flag    = zcf_reg;
  assign o_s_axi_awready      = awr_reg;
  assign o_s_axi_wready       = wr_reg;
  assign o_s_axi_bresp        = br_reg;
  assign o_s_axi_bvalid       = bv_reg;
  assign o_s_axi_arready      = arr_reg;
  assign o_s_axi_rdata        = rd_reg;
  assign o_s_axi_rresp        = rr_reg;
  assign o_s_axi_rvalid       = rv_reg;

  property p_lim_off;
    @(posedge i_ref_clk) disable iff (!i_rst_n) lim_lat_reg |=> !drv_reg;
  endproperty
  a_lim_off: assert property (p_lim_off) else $error("driver on during overcurrent");
  property p_lim_clr;
    @(posedge i_ref_clk) disable iff (!i_rst_n) !gate_reg |=> !lim_lat_reg;
  endproperty
  a_lim_clr: assert property (p_lim_clr) else $error("overcurrent kept after gate low");
  property p_class;
    @(posedge i_ref_clk) disable iff (!i_rst_n) $rose(ds_lat_reg) |-> !$past(lim_won_reg);
  endproperty
  a_class: assert property (p_class) else $error("desaturation after overcurrent");
  property p_slow;
    @(posedge i_ref_clk) disable iff (!i_rst_n) ds_lat_reg |-> slow_reg ##1 !drv_reg;
  endproperty
  a_slow: assert property (p_slow) else $error("desaturation without slow turn-off");
  property p_ds_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n) ds_lat_reg && gate_reg |=> ds_lat_reg;
  endproperty
  a_ds_hold: assert property (p_ds_hold) else $error("desaturation released with gate high");
  property p_flt;
    @(posedge i_ref_clk) disable iff (!i_rst_n) fault_any |=> !flt_reg;
  endproperty
  a_flt: assert property (p_flt) else $error("fault pin high with fault active");
  property p_ot_uv;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (cmp_reg.over_temp || cmp_reg.supply_undervolt_lockout) |=> !drv_reg;
  endproperty
  a_ot_uv: assert property (p_ot_uv) else $error("driver on in temperature or supply fault");
  property p_pin_in;
    @(posedge i_ref_clk) disable iff (!i_rst_n) !sensed_reg |-> !oe_reg && !drv_reg;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("pin driven while sensing");
  property p_zv_none;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      rise && zv_st_reg == ZV_IDLE && rc_reg < RC_MIN_CYC |=> zv_st_reg == ZV_IDLE;
  endproperty
  a_zv_none: assert property (p_zv_none) else $error("zero-volt pulse without qualifying run");
  property p_zc_blank;
    @(posedge i_ref_clk) disable iff (!i_rst_n) zc_st_reg == ZC_BLANK |-> !zcf_reg;
  endproperty
  a_zc_blank: assert property (p_zc_blank) else $error("zero-cross flag during blanking");
endmodule

// >>> verilog/pspd_pkg.sv
package pspd_pkg;
  // Clock period of i_ref_clk
  localparam int CLK_NS        = 20;
  // Times in ns (plain defaults; nothing fixes these values)
  localparam int TRIP_NS       = 100;    // current_trip_delay
  localparam int DESAT_RST_NS  = 10000;  // Gate-low time that releases a desaturation latch
  localparam int SENSE_NS      = 20000;  // Power-up drive-strength sensing window
  localparam int ZV_DLY_NS     = 60;     // zv_pulse_delay
  localparam int ZV_WID_NS     = 200;    // zv_pulse_width
  localparam int RC_MIN_NS     = 40;     // reverse_conduct_min
  localparam int ZC_BLANK_NS   = 100;    // zc_blank_time
  localparam int ZC_DLY_NS     = 40;     // zc_detect_delay
  localparam int ZC_WID_NS     = 200;    // Zero-cross pulse width
  // Least times, rounded up to whole cycles
  localparam logic [15:0] TRIP_CYC      = 16'((TRIP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] DESAT_RST_CYC = 16'((DESAT_RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] SENSE_CYC     = 16'((SENSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ZV_DLY_CYC    = 16'((ZV_DLY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ZV_WID_CYC    = 16'((ZV_WID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RC_MIN_CYC    = 16'((RC_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ZC_BLANK_CYC  = 16'((ZC_BLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ZC_DLY_CYC    = 16'((ZC_DLY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ZC_WID_CYC    = 16'((ZC_WID_NS + CLK_NS - 1) / CLK_NS);
  // Register map (byte addresses)
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  STAT_OFS      = 4'h4;
  localparam logic [1:0]  CTRL_RST      = 2'h3;
  localparam int          CTRL_ZV_EN    = 0;
  localparam int          CTRL_ZC_EN    = 1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Comparator flags from the analog front end
  typedef struct packed {
    logic current_overlimit;
    logic desaturation_trip;
    logic over_temp;
    logic supply_undervolt_lockout;
    logic vds_negative;
    logic current_positive;
  } pspd_cmp_s;
  typedef enum logic [1:0] {ZV_IDLE, ZV_WAIT, ZV_PULSE} pspd_zv_e;
  typedef enum logic [1:0] {ZC_IDLE, ZC_BLANK, ZC_SEEK, ZC_PULSE} pspd_zc_e;
endpackage

// >>> verif/pspd_pwm_model.sv
`timescale 1ns/1ps
// Far-side controller: drives the gate command, reads the fault pin
module pspd_pwm_model (
  input  wire logic i_ref_clk,
  input  wire logic i_fault_n,
  output logic      o_gate_cmd
);
  int n_flt = 0; // Fault cycles seen while asking for on
  initial o_gate_cmd = 1'h0;
  // One gate period; every change lands just after an edge
  task automatic pulse(input int hi, input int lo);
    o_gate_cmd <= 1'h1;
    repeat (hi) @(posedge i_ref_clk);
    o_gate_cmd <= 1'h0;
    repeat (lo) @(posedge i_ref_clk); // A long low here clears a latched trip
  endtask
  // CMOS thresholds: the sensing level counts as a fault, never as clear
  always @(posedge i_ref_clk) begin
    if (o_gate_cmd && !i_fault_n) n_flt++;
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pspd_pkg::*;
  localparam int ZW = ZV_WID_CYC;
  localparam int CW = ZC_WID_CYC;
  // Row: comparator levels, then counts of gate on, fault low, slow, zv, zc
  typedef struct {pspd_cmp_s cmp; int e[5];} pspd_row_s;
  pspd_row_s   rows[6] = '{'{6'h00, '{30, 0, 0, 0, 0}}, '{6'h01, '{30, 0, 0, 0, CW}},
                           '{6'h02, '{30, 0, 0, ZW, 0}}, '{6'h08, '{0, 60, 0, 0, 0}},
                           '{6'h04, '{0, 60, 0, 0, 0}}, '{6'h00, '{30, 0, 0, 0, 0}}};
  logic        i_ref_clk = '0;
  logic        i_rst_n = '0;
  pspd_cmp_s   i_cmp = '0;
  logic [3:0]  i_strength_code = 4'ha;
  logic [3:0]  i_s_axi_awaddr = '0, i_s_axi_araddr = '0, o_drive_code;
  logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata, q;
  logic        i_s_axi_awvalid = '0, i_s_axi_wvalid = '0, i_s_axi_bready = '0;
  logic        i_s_axi_arvalid = '0, i_s_axi_rready = '0, i_gate_cmd, i_fault_strap_pin;
  logic        o_fault_strap_pin, o_fault_strap_pin_oe, o_gate_on, o_slow_turnoff, o_zero_volt_flag;
  logic        o_zero_cross_flag, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic        o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, r;
  logic [4:0]  v;
  int          miscompares = 0, n_compared = 0, c[5];
  always #10 i_ref_clk = ~i_ref_clk;
  // Undriven pin during sensing reads low at CMOS levels
  assign i_fault_strap_pin = o_fault_strap_pin_oe ? o_fault_strap_pin : 1'h0;
  pspd_top DUT (
    .i_ref_clk, .i_rst_n, .i_gate_cmd, .i_cmp, .i_strength_code, .i_fault_strap_pin, .o_fault_strap_pin,
    .o_fault_strap_pin_oe, .o_gate_on, .o_slow_turnoff, .o_drive_code, .o_zero_volt_flag, .o_zero_cross_flag,
    .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb(4'hf),
    .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready
  );
  pspd_pwm_model pwm (.i_ref_clk, .i_fault_n(i_fault_strap_pin), .o_gate_cmd(i_gate_cmd));
  // Value compare; case inequality so an unknown matches only an unknown in the same bit of e
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read data and response code of the last bus transfer
  task automatic chk_rsp(input logic [31:0] ed, input logic [1:0] er);
    chk(q, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One bus transfer: request held until taken, answer taken at the edge it shows
  task automatic axi(input bit wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge i_ref_clk);
    i_s_axi_awaddr  <= a;
    i_s_axi_araddr  <= a;
    i_s_axi_wdata   <= d;
    i_s_axi_awvalid <= wr;
    i_s_axi_wvalid  <= wr;
    i_s_axi_bready  <= wr;
    i_s_axi_arvalid <= !wr;
    i_s_axi_rready  <= !wr;
    for (k = 0; k < 50; k++) begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
      if (o_s_axi_bvalid || o_s_axi_rvalid) break;
    end
    q = o_s_axi_rdata;
    r = wr ? o_s_axi_bresp : o_s_axi_rresp;
    i_s_axi_bready <= 1'h0;
    i_s_axi_rready <= 1'h0;
    if (k == 50) begin
      miscompares++;
      final_report();
    end
  endtask
  // One gate period of hi+30 cycles, counting cycles of each output state
  task automatic run(input int hi);
    c = '{5{0}};
    fork
      pwm.pulse(hi, 30);
      repeat (hi + 30) begin
        @(posedge i_ref_clk);
        v = {o_zero_cross_flag, o_zero_volt_flag, o_slow_turnoff, ~o_fault_strap_pin, o_gate_on};
        foreach (c[j]) c[j] += int'(v[j] === 1'h1);
      end
    join
  endtask
  // Gate period of 30 high and 30 low with comparators set to cv from cycle at for len cycles
  task automatic ev(input int at, input int len, input pspd_cmp_s cv);
    fork
      run(30);
      begin
        repeat (at) @(posedge i_ref_clk);
        i_cmp <= cv;
        repeat (len) @(posedge i_ref_clk);
        i_cmp <= '0;
      end
    join
  endtask
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    // Sensing window: gate ignored, fault low, pin not driven
    run(30);
    chk(o_fault_strap_pin_oe, 0);
    chk(c[0] * 100 + c[1], 60);
    chk(pwm.n_flt, 30);
    repeat (SENSE_CYC) @(posedge i_ref_clk);
    i_strength_code <= 4'h5;
    repeat (4) @(posedge i_ref_clk);
    chk({o_fault_strap_pin_oe, o_fault_strap_pin, o_drive_code}, 6'h3a);
    $display("sense test done");
    // Registers: reset value, status, write, unmapped both ways
    axi(0, CTRL_OFS, 0);
    chk_rsp(32'h3, RESP_OKAY);
    axi(0, STAT_OFS, 0);
    chk_rsp(32'h350, RESP_OKAY);
    axi(1, CTRL_OFS, 0);
    chk(r, RESP_OKAY);
    axi(1, STAT_OFS, 32'h1f);
    chk(r, RESP_OKAY);
    axi(0, STAT_OFS, 0);
    chk_rsp(32'h350, RESP_OKAY);
    axi(0, CTRL_OFS, 0);
    chk_rsp(32'h0, RESP_OKAY);
    axi(1, 4'h8, 5);
    chk(r, RESP_SLVERR);
    axi(0, 4'hc, 0);
    chk_rsp(32'h0, RESP_SLVERR);
    axi(1, CTRL_OFS, 3);
    $display("register test done");
    foreach (rows[i]) begin
      i_cmp <= rows[i].cmp;
      repeat (6) @(posedge i_ref_clk);
      run(30);
      foreach (c[j]) chk(c[j], rows[i].e[j]);
    end
    $display("table test done");
    // Reverse conduction of one cycle just before the rise
    i_cmp <= 6'h02;
    @(posedge i_ref_clk);
    ev(0, 1, 6'h02);
    chk(c[3], 0);
    ev(1, 3, 6'h01);
    chk(c[4], 0);
    ev(12, 40, 6'h01);
    chk(c[4], CW);
    ev(2, 25, 6'h20);
    chk(c[0] > 0 && c[0] < 30 && c[1] > 0, 1);
    run(30);
    chk(c[0] * 100 + c[1], 3000);
    i_cmp <= 6'h20;
    ev(10, 10, 6'h30);
    chk(c[2], 0);
    ev(10, 5, 6'h10);
    chk(c[0] < 30 && c[1] > 0 && c[2] > 0, 1);
    run(30);
    chk(c[0] * 100 + c[2], 60);
    repeat (DESAT_RST_CYC + 10) @(posedge i_ref_clk);
    run(30);
    chk(c[0] * 100 + c[2], 3000);
    $display("protection test done");
    // Reset in mid-run: sensing starts over, pin released, driver held off
    i_rst_n <= 1'h0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    run(30);
    chk(o_fault_strap_pin_oe, 0);
    chk(c[0] * 100 + c[1], 60);
    $display("reset test done");
    final_report();
  end
endmodule
